// ---- verilog/wdk_pkg.sv ----
// package with register map, fields, keys and timing counts for the double-key watchdog
package wdk_pkg;
  localparam logic [7:0] WDK_ADDR_MASTER = 8'hF0;
  localparam logic [7:0] WDK_ADDR_KEY = 8'hF1;
  localparam int WDK_RUN_BIT = 7;
  localparam int WDK_PER_HI = 6;
  localparam int WDK_PER_LO = 5;
  localparam int WDK_PD_HI = 4;
  localparam int WDK_PD_LO = 3;
  localparam logic [2:0] WDK_RSVD_VAL = 3'h3;
  localparam logic [7:0] WDK_KEY_DISABLE = 8'hB1;
  localparam logic [7:0] WDK_KEY_RESTART = 8'h4E;
  localparam logic [7:0] WDK_KEY_PD_UNLOCK = 8'hDB;
  localparam logic [7:0] WDK_KEY_READ_VAL = 8'hFF;
  localparam logic WDK_RUN_RESET = 1'b1;
  localparam logic [1:0] WDK_PER_RESET = 2'h3;
  localparam int WDK_CNT_W = 22;
  localparam int WDK_EXP_BASE = 16;
  localparam int WDK_EXP_STEP = 2;
  localparam real WDK_CLK_NS = 25.0;

  typedef enum logic [1:0] {
    WDK_PD_IDLE1 = 2'b00,
    WDK_PD_IDLE2 = 2'b01,
    WDK_PD_STOP = 2'b10,
    WDK_PD_RUN = 2'b11
  } wdk_pd_mode_t;

  typedef struct packed {
    logic run_enable;
    logic [1:0] period_select;
    wdk_pd_mode_t power_down_select;
  } wdk_master_t;

  typedef struct packed {
    logic idle1;
    logic idle2;
    logic stop;
    logic run;
  } wdk_pd_decode_t;
endpackage

// ---- verilog/wdk_counter.sv ----
// free-running period counter with terminal detect for the watchdog
`timescale 1ns/1ps
module wdk_counter
  import wdk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic count_en,
  input wire logic restart,
  input wire logic [1:0] period_select,
  output logic terminal
);
  logic [WDK_CNT_W-1:0] cnt_q;
  logic [WDK_CNT_W-1:0] limit;

  function automatic logic [WDK_CNT_W-1:0] period_limit(input logic [1:0] sel);
    logic [WDK_CNT_W-1:0] ones;
    ones = '1;
    period_limit = ones >> (WDK_CNT_W - WDK_EXP_BASE - WDK_EXP_STEP * int'(sel));
  endfunction

  assign limit = period_limit(period_select);
  assign terminal = count_en && !restart && (cnt_q == limit);

  // a restart key has priority so a kick in the last cycle still saves the system
  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
    begin
      cnt_q <= '0;
    end
    else if (count_en)
    begin
      if (cnt_q >= limit)
      begin
        cnt_q <= '0;
      end
      else
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// ---- verilog/wdk_top.sv ----
// double-key watchdog with master and key I/O registers and power-down select
// How it works
// - bit 7 set with period enables watchdog
// - stop needs enable cleared then B1h key
// - 4Eh key restarts count from zero
// - reset leaves the watchdog enabled
// - period is clock times 2^16..2^22
// - reset period select is longest, 11
// - power-down field changes only after DBh key
// - decode power-down 00,01,10,11 to four modes
// - reset power-down field is run mode
// - reserved bits read back as 011
// - key register is write only
// - master at F0h, key at F1h
`timescale 1ns/1ps
module wdk_top
  import wdk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata_q,
  output logic io_rvalid_q,
  output logic wd_timeout_q,
  output logic wd_active_q,
  output logic pd_idle1_q,
  output logic pd_idle2_q,
  output logic pd_stop_q,
  output logic pd_run_q
);
  wdk_master_t mreg_q;
  logic counting_q;
  logic unlock_q;
  logic wr_master;
  logic wr_key;
  logic rd_master;
  logic rd_key;
  logic restart;
  logic terminal;
  wdk_pd_decode_t pd_dec;

  function automatic wdk_pd_decode_t decode_pd(input wdk_pd_mode_t m);
    decode_pd = '{idle1: m == WDK_PD_IDLE1, idle2: m == WDK_PD_IDLE2,
      stop: m == WDK_PD_STOP, run: m == WDK_PD_RUN};
  endfunction

  always_comb
  begin
    wr_master = 1'b0;
    wr_key = 1'b0;
    rd_master = 1'b0;
    rd_key = 1'b0;
    if (io_addr == WDK_ADDR_MASTER)
    begin
      wr_master = io_wr;
      rd_master = io_rd;
    end
    else if (io_addr == WDK_ADDR_KEY)
    begin
      wr_key = io_wr;
      rd_key = io_rd;
    end
  end

  assign restart = wr_key && (io_wdata == WDK_KEY_RESTART);
  assign pd_dec = decode_pd(mreg_q.power_down_select);

  // master register; reserved bits written by software are dropped, they read as a constant
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mreg_q.run_enable <= WDK_RUN_RESET;
      mreg_q.period_select <= WDK_PER_RESET;
      mreg_q.power_down_select <= WDK_PD_RUN;
    end
    else if (wr_master)
    begin
      mreg_q.run_enable <= io_wdata[WDK_RUN_BIT];
      mreg_q.period_select <= io_wdata[WDK_PER_HI:WDK_PER_LO];
      if (unlock_q)
      begin
        mreg_q.power_down_select <= wdk_pd_mode_t'(io_wdata[WDK_PD_HI:WDK_PD_LO]);
      end
    end
  end

  // unlock lasts until the next master write, which consumes it, or until a key write other than DBh
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      unlock_q <= 1'b0;
    end
    else if (wr_key)
    begin
      unlock_q <= (io_wdata == WDK_KEY_PD_UNLOCK);
    end
    else if (wr_master)
    begin
      unlock_q <= 1'b0;
    end
  end

  // clearing the enable bit only arms; counting stops on the B1h key written after it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      counting_q <= WDK_RUN_RESET;
    end
    else if (mreg_q.run_enable || (wr_master && io_wdata[WDK_RUN_BIT]))
    begin
      counting_q <= 1'b1;
    end
    else if (wr_key && io_wdata == WDK_KEY_DISABLE)
    begin
      counting_q <= 1'b0;
    end
  end

  wdk_counter u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .count_en(counting_q),
    .restart(restart),
    .period_select(mreg_q.period_select),
    .terminal(terminal)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wd_timeout_q <= 1'b0;
      wd_active_q <= 1'b0;
    end
    else
    begin
      wd_timeout_q <= terminal;
      wd_active_q <= counting_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pd_idle1_q <= 1'b0;
      pd_idle2_q <= 1'b0;
      pd_stop_q <= 1'b0;
      pd_run_q <= 1'b0;
    end
    else
    begin
      pd_idle1_q <= pd_dec.idle1;
      pd_idle2_q <= pd_dec.idle2;
      pd_stop_q <= pd_dec.stop;
      pd_run_q <= pd_dec.run;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      io_rdata_q <= '0;
      io_rvalid_q <= 1'b0;
    end
    else
    begin
      io_rvalid_q <= io_rd;
      if (rd_master)
      begin
        io_rdata_q <= {mreg_q, WDK_RSVD_VAL};
      end
      else if (rd_key)
      begin
        io_rdata_q <= WDK_KEY_READ_VAL;
      end
      else
      begin
        io_rdata_q <= '0;
      end
    end
  end

  property p_disable_needs_key;
    @(posedge clk_sys) disable iff (rst)
      (counting_q && !(wr_key && io_wdata == WDK_KEY_DISABLE)) |=> counting_q;
  endproperty
  a_disable_needs_key: assert property (p_disable_needs_key) else $error("watchdog stopped without key");

  property p_key_stops;
    @(posedge clk_sys) disable iff (rst)
      (wr_key && io_wdata == WDK_KEY_DISABLE && !mreg_q.run_enable) |=> !counting_q;
  endproperty
  a_key_stops: assert property (p_key_stops) else $error("disable key ignored");

  property p_enable_starts;
    @(posedge clk_sys) disable iff (rst)
      (wr_master && io_wdata[WDK_RUN_BIT]) |=> ##1 counting_q && wd_active_q;
  endproperty
  a_enable_starts: assert property (p_enable_starts) else $error("enable did not start watchdog");

  property p_restart_no_timeout;
    @(posedge clk_sys) disable iff (rst)
      restart |=> !wd_timeout_q [*8];
  endproperty
  a_restart_no_timeout: assert property (p_restart_no_timeout) else $error("timeout after restart");

  property p_pd_locked;
    @(posedge clk_sys) disable iff (rst)
      (!unlock_q) |=> $stable(mreg_q.power_down_select);
  endproperty
  a_pd_locked: assert property (p_pd_locked) else $error("power-down changed without key");

  property p_pd_unlock;
    @(posedge clk_sys) disable iff (rst)
      (wr_key && io_wdata == WDK_KEY_PD_UNLOCK) ##1 (wr_master && !wr_key)
        |=> mreg_q.power_down_select == $past(io_wdata[WDK_PD_HI:WDK_PD_LO]);
  endproperty
  a_pd_unlock: assert property (p_pd_unlock) else $error("unlocked mode write lost");

  // started only outside reset: the outputs sit at zero for one edge after release
  property p_pd_decode;
    @(posedge clk_sys) disable iff (rst)
      !rst |=> ({pd_idle1_q, pd_idle2_q, pd_stop_q, pd_run_q}
        == {$past(mreg_q.power_down_select) == WDK_PD_IDLE1,
          $past(mreg_q.power_down_select) == WDK_PD_IDLE2,
          $past(mreg_q.power_down_select) == WDK_PD_STOP,
          $past(mreg_q.power_down_select) == WDK_PD_RUN})
        && ($countones({pd_idle1_q, pd_idle2_q, pd_stop_q, pd_run_q}) == 1);
  endproperty
  a_pd_decode: assert property (p_pd_decode) else $error("power-down decode wrong");

  property p_reserved_read;
    @(posedge clk_sys) disable iff (rst)
      rd_master |=> io_rdata_q[2:0] == WDK_RSVD_VAL && io_rvalid_q;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits not 011");

  property p_key_read;
    @(posedge clk_sys) disable iff (rst)
      rd_key |=> io_rdata_q == WDK_KEY_READ_VAL;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key register read not constant");

  property p_reset_defaults;
    @(posedge clk_sys)
      rst |=> mreg_q.run_enable && mreg_q.period_select == WDK_PER_RESET
        && mreg_q.power_down_select == WDK_PD_RUN && counting_q;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

  property p_timeout_pulse;
    @(posedge clk_sys) disable iff (rst)
      wd_timeout_q |=> !wd_timeout_q;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout not one pulse");
endmodule

// ---- sim/wdk_host_model.sv ----
// host cpu model issuing i/o writes and reads to the watchdog registers
`timescale 1ns/1ps
module wdk_host_model
  import wdk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic io_rvalid_q,
  input wire logic [7:0] io_rdata_q,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd
);
  initial
  begin
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end

  // released lines carry the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    io_addr <= ~a;
    @(posedge clk_sys);
    d = io_rdata_q;
    v = io_rvalid_q;
  endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the double-key watchdog
`timescale 1ns/1ps
module tb;
  import wdk_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] io_addr, io_wdata, io_rdata_q;
  logic io_wr, io_rd, io_rvalid_q, wd_timeout_q, wd_active_q;
  wire [3:0] pd;
  int error_cnt = 0;
  int num_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  wdk_top u_dut (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
    .wd_timeout_q(wd_timeout_q), .wd_active_q(wd_active_q), .pd_idle1_q(pd[3]),
    .pd_idle2_q(pd[2]), .pd_stop_q(pd[1]), .pd_run_q(pd[0]));

  wdk_host_model u_host (.clk_sys(clk_sys), .io_rvalid_q(io_rvalid_q),
    .io_rdata_q(io_rdata_q), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk({n, "_valid"}, 8'h01, {7'h00, v});
    chk(n, e, d);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    settle();
    chk("active", 8'h01, {7'h00, wd_active_q});
    chk("pd", 8'h01, {4'h0, pd});
    rd_chk("master", WDK_ADDR_MASTER, 8'hFB);
    rd_chk("key", WDK_ADDR_KEY, WDK_KEY_READ_VAL);
    rd_chk("unmapped", 8'hF2, 8'h00);
  endtask

  task automatic t_pd;
    logic [1:0] m;
    u_host.wr(WDK_ADDR_MASTER, 8'hE3);
    rd_chk("locked", WDK_ADDR_MASTER, 8'hFB);
    m = 2'h0;
    repeat (4)
    begin
      u_host.wr(WDK_ADDR_KEY, WDK_KEY_PD_UNLOCK);
      u_host.wr(WDK_ADDR_MASTER, {3'h7, m, 3'h3});
      settle();
      chk("pd_dec", {4'h0, 4'h8 >> m}, {4'h0, pd});
      rd_chk("unlocked", WDK_ADDR_MASTER, {3'h7, m, 3'h3});
      m++;
    end
  endtask

  task automatic t_disable;
    u_host.wr(WDK_ADDR_KEY, WDK_KEY_DISABLE);
    settle();
    chk("active", 8'h01, {7'h00, wd_active_q});
    u_host.wr(WDK_ADDR_MASTER, 8'h7B);
    settle();
    chk("active", 8'h01, {7'h00, wd_active_q});
    rd_chk("cleared", WDK_ADDR_MASTER, 8'h7B);
    u_host.wr(WDK_ADDR_KEY, WDK_KEY_DISABLE);
    settle();
    chk("active", 8'h00, {7'h00, wd_active_q});
    u_host.wr(WDK_ADDR_MASTER, 8'h9B);
    settle();
    chk("active", 8'h01, {7'h00, wd_active_q});
  endtask

  // shortest period only; the longer codes would need 2^18 to 2^22 cycles
  task automatic t_period;
    int n;
    int hits;
    hits = 0;
    u_host.wr(WDK_ADDR_KEY, WDK_KEY_RESTART);
    repeat (20000)
    begin
      @(posedge clk_sys);
      hits += int'(wd_timeout_q === 1'b1);
    end
    chk("early_timeouts", 8'h00, 8'(hits));
    u_host.wr(WDK_ADDR_KEY, WDK_KEY_RESTART);
    n = 0;
    while (wd_timeout_q !== 1'b1 && n < 70000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("period_ok", 8'h01, {7'h00, n >= 65536 && n <= 65538});
    @(posedge clk_sys);
    chk("pulse_end", 8'h00, {7'h00, wd_timeout_q});
  endtask

  initial
  begin
    #(25.0 * 99000);
    error_cnt++;
    $display("unexpected run_time exp done got hang");
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_pd();
    t_disable();
    t_period();
    end_of_test();
  end
endmodule
